// ---- rtl/mpfc_map.vh ----
`ifndef MPFC_MAP_VH
`define MPFC_MAP_VH
// Register word indexes on the APB port; byte address is index times four
`define MPFC_IDX_CTRL        4'h0
`define MPFC_IDX_STAT        4'h1
`define MPFC_IDX_W           4
`define MPFC_ADDR_LSB        2
// Control register layout and reset value
`define MPFC_IGN_LSB         0
`define MPFC_IGN_MSB         7
`define MPFC_FWD_BIT         16
`define MPFC_CTRL_RST        32'h0001_00ff
`define MPFC_CTRL_MASK       32'h0001_00ff
// Frame fields
`define MPFC_ETYPE_CTRL      16'h8808
`define MPFC_OP_PAUSE        16'h0001
`define MPFC_OP_PFC          16'h0101
`define MPFC_POS_ETYPE_HI    6'h0c
`define MPFC_POS_ETYPE_LO    6'h0d
`define MPFC_POS_OP_HI       6'h0e
`define MPFC_POS_OP_LO       6'h0f
`define MPFC_POS_CEV_HI      6'h10
`define MPFC_POS_CEV_LO      6'h11
`define MPFC_POS_QUANTA      6'h12
`define MPFC_POS_END         6'h22
// One pause quantum is 512 bit times at 10 Gb/s
`define MPFC_QUANTUM_PS      51200
`define MPFC_CLK_PS          40000
`define MPFC_QUANTUM_CYC     ((`MPFC_QUANTUM_PS + `MPFC_CLK_PS - 1) / `MPFC_CLK_PS)
`endif

// ---- rtl/mpfc_rx_pfc.v ----
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mpfc_map.vh"
module mpfc_rx_pfc #(
  parameter integer PRIOS    = 8,
  parameter integer DLY      = 17,
  parameter integer QCYC     = `MPFC_QUANTUM_CYC
)(
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [15:0]          paddr,
  input  wire [31:0]          pwdata,
  output wire                 pready,
  output reg  [31:0]          prdata,
  output wire                 pslverr,
  input  wire                 ctrl_frame_pass_to_client,
  input  wire                 rx_in_valid,
  input  wire                 rx_in_sop,
  input  wire                 rx_in_eop,
  input  wire                 rx_in_err,
  input  wire [7:0]           rx_in_data,
  output wire                 rx_out_valid,
  output wire                 rx_out_sop,
  output wire                 rx_out_eop,
  output wire                 rx_out_err,
  output wire [7:0]           rx_out_data,
  output wire [PRIOS-1:0]     tx_prio_pause
);

  function [`MPFC_IDX_W-1:0] word_idx;
    input [15:0] a;
    begin
      word_idx = a[`MPFC_ADDR_LSB +: `MPFC_IDX_W];
    end
  endfunction

  function mapped;
    input [15:0] a;
    begin
      mapped = (a[15:`MPFC_ADDR_LSB + `MPFC_IDX_W] == 0) && (a[`MPFC_ADDR_LSB-1:0] == 2'b00) &&
               ((word_idx(a) == `MPFC_IDX_CTRL) || (word_idx(a) == `MPFC_IDX_STAT));
    end
  endfunction

  // ---------------- APB register port ----------------
  reg  [31:0] ctrl_reg;
  wire        wr_en = psel & penable & pwrite;
  wire [PRIOS-1:0] ignore_bits = ctrl_reg[`MPFC_IGN_MSB:`MPFC_IGN_LSB];
  wire        prio_frame_pass_to_client = ctrl_reg[`MPFC_FWD_BIT];

  // Unmapped words answer with an error, never a hang
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= `MPFC_CTRL_RST;
    else if (wr_en && mapped(paddr) && word_idx(paddr) == `MPFC_IDX_CTRL)
      ctrl_reg <= pwdata & `MPFC_CTRL_MASK;
  end

  // Read data registered in the setup cycle so it is stable in the access cycle of the same read
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite && mapped(paddr))
    begin
      if (word_idx(paddr) == `MPFC_IDX_CTRL)
        prdata <= ctrl_reg;
      else
        // Live pause vector, one cycle old by the access phase
        prdata <= {{(32-PRIOS){1'b0}}, tx_prio_pause};
    end
    else if (psel && !penable)
      prdata <= 32'h0000_0000;
  end

  // ---------------- Receive frame parser ----------------
  reg  [5:0]  pos_reg;
  reg  [15:0] etype_reg;
  reg  [15:0] op_reg;
  reg  [7:0]  cev_reg;
  reg  [7:0]  q_hi_reg [0:PRIOS-1];
  reg  [7:0]  q_lo_reg [0:PRIOS-1];
  reg         pend_drop_reg;
  reg         act_reg;
  wire [5:0]  pos = rx_in_sop ? 6'h00 : pos_reg;
  wire        in_byte = rx_in_valid;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_reg   <= 6'h00;
      etype_reg <= 16'h0000;
      op_reg    <= 16'h0000;
      cev_reg   <= 8'h00;
    end
    else if (in_byte)
    begin
      if (pos != `MPFC_POS_END)
        pos_reg <= pos + 6'h01;
      else
        pos_reg <= pos;
      if (rx_in_sop)
      begin
        etype_reg <= 16'h0000;
        op_reg    <= 16'h0000;
        cev_reg   <= 8'h00;
      end
      else
      begin
        if (pos == `MPFC_POS_ETYPE_HI)
          etype_reg[15:8] <= rx_in_data;
        if (pos == `MPFC_POS_ETYPE_LO)
          etype_reg[7:0] <= rx_in_data;
        if (pos == `MPFC_POS_OP_HI)
          op_reg[15:8] <= rx_in_data;
        // Low opcode byte lands with the drop decision
        if (pos == `MPFC_POS_OP_LO)
          op_reg[7:0] <= rx_in_data;
        if (pos == `MPFC_POS_CEV_LO)
          cev_reg <= rx_in_data;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PRIOS; gi = gi + 1)
    begin : g_quanta
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          q_hi_reg[gi] <= 8'h00;
          q_lo_reg[gi] <= 8'h00;
        end
        else if (in_byte && pos == `MPFC_POS_QUANTA + 2 * gi)
          q_hi_reg[gi] <= rx_in_data;
        else if (in_byte && pos == `MPFC_POS_QUANTA + 2 * gi + 1)
          q_lo_reg[gi] <= rx_in_data;
      end
    end
  endgenerate

  // Classification once the opcode is complete, while the frame start is still in the delay line
  wire        op_done  = in_byte && !rx_in_sop && pos == `MPFC_POS_OP_LO;
  wire [15:0] op_now   = {op_reg[15:8], rx_in_data};
  wire        is_ctrl  = etype_reg == `MPFC_ETYPE_CTRL;
  wire        is_pfc   = is_ctrl && op_now == `MPFC_OP_PFC;
  wire        is_pause = is_ctrl && op_now == `MPFC_OP_PAUSE;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_drop_reg <= 1'b0;
    else if (in_byte && rx_in_sop)
      pend_drop_reg <= 1'b0;
    else if (op_done)
    begin
      if (is_pfc)
        pend_drop_reg <= ~prio_frame_pass_to_client;
      else if (is_ctrl && !is_pause)
        pend_drop_reg <= ~ctrl_frame_pass_to_client;
      else
        pend_drop_reg <= 1'b0;
    end
  end

  // Pause quanta act only on a complete, error-free PFC frame
  wire pfc_frame = etype_reg == `MPFC_ETYPE_CTRL && op_reg == `MPFC_OP_PFC;
  wire frame_ok  = in_byte && rx_in_eop && !rx_in_err && !rx_in_sop && pos == `MPFC_POS_END;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_reg <= 1'b0;
    else
      act_reg <= frame_ok && pfc_frame;
  end

  // ---------------- Per-priority pause timers ----------------
  generate
    for (gi = 0; gi < PRIOS; gi = gi + 1)
    begin : g_timer
      reg [15:0] quanta_reg;
      reg [15:0] sub_reg;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          quanta_reg <= 16'h0000;
          sub_reg    <= 16'h0000;
        end
        // Ignore wins over a load in the same cycle, so the queue resumes at once
        else if (ignore_bits[gi])
        begin
          quanta_reg <= 16'h0000;
          sub_reg    <= 16'h0000;
        end
        else if (act_reg && cev_reg[gi])
        begin
          quanta_reg <= {q_hi_reg[gi], q_lo_reg[gi]};
          sub_reg    <= 16'h0000;
        end
        else if (quanta_reg != 16'h0000)
        begin
          if (sub_reg == QCYC[15:0] - 16'h0001)
          begin
            sub_reg    <= 16'h0000;
            quanta_reg <= quanta_reg - 16'h0001;
          end
          else
            sub_reg <= sub_reg + 16'h0001;
        end
      end
      assign tx_prio_pause[gi] = quanta_reg != 16'h0000;
    end
  endgenerate

  // ---------------- Client delay line ----------------
  // Holds the frame head until it is known whether the frame is dropped
  reg [DLY-1:0] dv_reg;
  reg [DLY-1:0] ds_reg;
  reg [DLY-1:0] de_reg;
  reg [DLY-1:0] dr_reg;
  reg [7:0]     dd_reg [0:DLY-1];
  reg           cur_drop_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dv_reg <= {DLY{1'b0}};
      ds_reg <= {DLY{1'b0}};
      de_reg <= {DLY{1'b0}};
      dr_reg <= {DLY{1'b0}};
    end
    else
    begin
      dv_reg <= {dv_reg[DLY-2:0], rx_in_valid};
      ds_reg <= {ds_reg[DLY-2:0], rx_in_valid & rx_in_sop};
      de_reg <= {de_reg[DLY-2:0], rx_in_valid & rx_in_eop};
      dr_reg <= {dr_reg[DLY-2:0], rx_in_valid & rx_in_err};
    end
  end

  // First stage apart, so no stage ever indexes below zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dd_reg[0] <= 8'h00;
    else
      dd_reg[0] <= rx_in_data;
  end

  generate
    for (gi = 1; gi < DLY; gi = gi + 1)
    begin : g_dly
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          dd_reg[gi] <= 8'h00;
        else
          dd_reg[gi] <= dd_reg[gi-1];
      end
    end
  endgenerate

  // Drop decision moves with the frame start into the last stage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_drop_reg <= 1'b0;
    else if (dv_reg[DLY-2] && ds_reg[DLY-2])
      cur_drop_reg <= pend_drop_reg;
  end

  assign rx_out_valid = dv_reg[DLY-1] & ~cur_drop_reg;
  assign rx_out_sop   = ds_reg[DLY-1];
  assign rx_out_eop   = de_reg[DLY-1];
  assign rx_out_err   = dr_reg[DLY-1];
  assign rx_out_data  = dd_reg[DLY-1];

endmodule
`default_nettype wire

// ---- testbench/mpfc_rx_pfc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpfc_rx_pfc_monitor #(
  parameter integer DLY = 17
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rx_in_valid,
  input wire logic        rx_in_eop,
  input wire logic [7:0]  rx_in_data,
  input wire logic        rx_out_valid,
  input wire logic [7:0]  rx_out_data,
  input wire logic [7:0]  tx_prio_pause
);
  logic [31:0] shadow_reg;
  logic [2:0]  eop_reg;
  wire         acc = psel & penable;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      shadow_reg <= 32'h0001_00ff;
      eop_reg    <= 3'h0;
    end
    else
    begin
      if (acc & pwrite & (paddr == 16'h0000))
        shadow_reg <= pwdata & 32'h0001_00ff;
      eop_reg <= {eop_reg[1:0], rx_in_valid & rx_in_eop};
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One cycle of grace: setting an ignore bit clears its timer on the next edge
  property p_ign; (shadow_reg[7:0] & $past(shadow_reg[7:0]) & tx_prio_pause) == 8'h00; endproperty
  a_ign: assert property (p_ign) else $error("pause on ignored priority");
  property p_rd; acc & !pwrite & (paddr == 16'h0000) |-> prdata == shadow_reg; endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  property p_stat; acc & !pwrite & (paddr == 16'h0004) |-> prdata == {24'h0, $past(tx_prio_pause)}; endproperty
  a_stat: assert property (p_stat) else $error("status readback wrong");
  property p_err; acc |-> pslverr == ((paddr[15:3] != 13'h0) || (paddr[1:0] != 2'h0)); endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_idle; !psel |-> !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("slave error while idle");
  property p_dat; rx_out_valid |-> rx_out_data == $past(rx_in_data, DLY); endproperty
  a_dat: assert property (p_dat) else $error("client byte wrong");
  property p_val; rx_out_valid |-> $past(rx_in_valid, DLY); endproperty
  a_val: assert property (p_val) else $error("client byte from nowhere");
  property p_rise; (tx_prio_pause & ~$past(tx_prio_pause)) != 8'h00 |-> eop_reg != 3'h0; endproperty
  a_rise: assert property (p_rise) else $error("pause without frame end");
  c_pause: cover property (tx_prio_pause != 8'h00);
  c_fwd: cover property (rx_out_valid);
  c_err: cover property (acc & pslverr);
endmodule
bind mpfc_rx_pfc mpfc_rx_pfc_monitor #(.DLY(DLY)) u_mpfc_rx_pfc_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .rx_in_valid(rx_in_valid), .rx_in_eop(rx_in_eop), .rx_in_data(rx_in_data),
  .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .tx_prio_pause(tx_prio_pause)
);
`default_nettype wire

// ---- testbench/mpfc_phy_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpfc_phy_model (
  input  wire logic       pclk,
  output var  logic       rx_in_valid,
  output var  logic       rx_in_sop,
  output var  logic       rx_in_eop,
  output var  logic       rx_in_err,
  output wire logic [7:0] rx_in_data
);
  logic [7:0] byte_q = 8'h00;
  logic [7:0] idle_q = 8'h5a;
  initial
  begin
    rx_in_valid = 1'b0;
    rx_in_sop = 1'b0;
    rx_in_eop = 1'b0;
    rx_in_err = 1'b0;
  end
  // Idle lane toggles so stale bytes never look valid
  always @(posedge pclk)
    idle_q <= ~idle_q;
  assign rx_in_data = rx_in_valid ? byte_q : idle_q;
  // 36-byte frame, class enable all, quanta of priority i is i+1
  task automatic send(input logic [15:0] et, input logic [15:0] op, input logic er);
    logic [7:0] b;
    for (int i = 0; i < 36; i++)
    begin
      case (i)
        12: b = et[15:8];
        13: b = et[7:0];
        14: b = op[15:8];
        15: b = op[7:0];
        17: b = 8'hff;
        default: b = (i >= 18 && i < 34 && i[0]) ? 8'((i - 17) >> 1) : 8'h00;
      endcase
      @(posedge pclk);
      rx_in_valid <= 1'b1;
      rx_in_sop <= (i == 0);
      rx_in_eop <= (i == 35);
      rx_in_err <= er && (i == 35);
      byte_q <= b;
    end
    @(posedge pclk);
    rx_in_valid <= 1'b0;
    rx_in_eop <= 1'b0;
    rx_in_err <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/mpfc_rx_pfc_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpfc_rx_pfc_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ctrl_pass = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  wire         pready, pslverr, rx_out_valid, rx_in_valid, rx_in_sop, rx_in_eop, rx_in_err;
  wire         rx_out_sop, rx_out_eop, rx_out_err;
  wire  [31:0] prdata;
  wire  [7:0]  rx_in_data, tx_prio_pause;
  int          n_errors = 0, n_compared = 0, n_out = 0;
  int          n_sop = 0, n_eop = 0, n_err = 0;
  int          hi_cnt [8] = '{default: 0};
  mpfc_rx_pfc #(.QCYC(1)) u_mpfc_rx_pfc (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ctrl_frame_pass_to_client(ctrl_pass), .rx_in_valid(rx_in_valid), .rx_in_sop(rx_in_sop),
    .rx_in_eop(rx_in_eop), .rx_in_err(rx_in_err), .rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid),
    .rx_out_sop(rx_out_sop), .rx_out_eop(rx_out_eop), .rx_out_err(rx_out_err), .rx_out_data(),
    .tx_prio_pause(tx_prio_pause));
  mpfc_phy_model u_mpfc_phy_model (.pclk(pclk), .rx_in_valid(rx_in_valid), .rx_in_sop(rx_in_sop),
    .rx_in_eop(rx_in_eop), .rx_in_err(rx_in_err), .rx_in_data(rx_in_data));
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    n_out <= n_out + rx_out_valid;
    n_sop <= n_sop + (rx_out_valid & rx_out_sop);
    n_eop <= n_eop + (rx_out_valid & rx_out_eop);
    n_err <= n_err + (rx_out_valid & rx_out_err);
    for (int i = 0; i < 8; i++)
      hi_cnt[i] <= hi_cnt[i] + tx_prio_pause[i];
  end
  task chk(input string s, input logic [32:0] e, input logic [32:0] g);
    n_compared++;
    if (e !== g)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk("apb", e, {pslverr, wr ? 32'h0 : prdata});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frm(input logic [15:0] et, input logic [15:0] op, input int n, input logic [7:0] m,
                     input logic er = 1'b0);
    int b_out, b_sop, b_eop, b_err;
    int b_hi [8];
    b_out = n_out;
    b_sop = n_sop;
    b_eop = n_eop;
    b_err = n_err;
    b_hi = hi_cnt;
    u_mpfc_phy_model.send(et, op, er);
    repeat (40) @(posedge pclk);
    chk("client bytes", 33'(n), 33'(n_out - b_out));
    chk("client sop", 33'(n != 0), 33'(n_sop - b_sop));
    chk("client eop", 33'(n != 0), 33'(n_eop - b_eop));
    chk("client err", 33'(n != 0 && er), 33'(n_err - b_err));
    for (int i = 0; i < 8; i++)
      chk("pause cycles", m[i] ? 33'(i + 1) : 33'h0, 33'(hi_cnt[i] - b_hi[i]));
  endtask
  task results;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 16'h0000, 32'h0, {1'b0, 32'h0001_00ff});
    apb(1'b0, 16'h0004, 32'h0, 33'h0);
    apb(1'b1, 16'h0000, 32'hffff_ffff, 33'h0);
    apb(1'b0, 16'h0000, 32'h0, {1'b0, 32'h0001_00ff});
    apb(1'b0, 16'h0008, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 16'h0002, 32'h0, {1'b1, 32'h0});
    frm(16'h8808, 16'h0101, 36, 8'h00);
    apb(1'b1, 16'h0000, 32'h0, 33'h0);
    frm(16'h8808, 16'h0101, 0, 8'hff);
    apb(1'b1, 16'h0000, 32'h0001_00f0, 33'h0);
    apb(1'b0, 16'h0000, 32'h0, {1'b0, 32'h0001_00f0});
    frm(16'h8808, 16'h0101, 36, 8'h0f);
    frm(16'h8808, 16'h0101, 36, 8'h00, 1'b1);
    frm(16'h0800, 16'h0000, 36, 8'h00);
    frm(16'h8808, 16'h0001, 36, 8'h00);
    frm(16'h8808, 16'h0002, 0, 8'h00);
    ctrl_pass <= 1'b1;
    frm(16'h8808, 16'h0002, 36, 8'h00);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 16'h0000, 32'h0, {1'b0, 32'h0001_00ff});
    results();
  end
  initial
  begin
    repeat (3000) @(posedge pclk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
